// ==== logic/wdnmi_consts.svh ====
// constants shared by the watchdog device, its core end and the bench
`ifndef WDNMI_CONSTS_SVH
`define WDNMI_CONSTS_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define WDNMI_SYS_HZ 25000000
`define WDNMI_LSO_HZ 32768
`define WDNMI_TICK_HZ 256
`define WDNMI_LSO_DIV (`WDNMI_SYS_HZ / `WDNMI_LSO_HZ)
`define WDNMI_PRE_W 7
`define WDNMI_PRE_LAST 7'h7F
`define WDNMI_CNT_W 10
`define WDNMI_CNT_LAST 10'h3FF
`define WDNMI_CNT_RST 10'h000

// ************************************************************
// watchdog control register
// ************************************************************
`define WDNMI_IO_AW 16
`define WDNMI_IO_DW 4
`define WDNMI_CTRL_ADDR 16'hFF07
`define WDNMI_RUN_EN_BIT 1
`define WDNMI_CLR_BIT 0
`define WDNMI_RUN_EN_RST 1'b1

// ************************************************************
// core end
// ************************************************************
`define WDNMI_NMI_VECTOR 16'h0100
`define WDNMI_PC_RST 16'h0000
`define WDNMI_AV_AW 5
`define WDNMI_OFS_WINDOW 5'h00
`define WDNMI_OFS_CORE_CTRL 5'h04
`define WDNMI_OFS_CORE_STAT 5'h08
`define WDNMI_OFS_IRQ_STAT 5'h0C
`define WDNMI_OFS_IRQ_MASK 5'h10
`define WDNMI_HALT_BIT 0
`define WDNMI_IDIS_BIT 1
`define WDNMI_SP1_BIT 2
`define WDNMI_SP2_BIT 3
`define WDNMI_MASKST_BIT 1
`define WDNMI_PC_LSB 16
`define WDNMI_EV_TAKEN 0
`define WDNMI_EV_WAKE 1
`define WDNMI_EV_W 2

`endif

// ==== logic/wdnmi_pkg.sv ====
// types shared by the watchdog device and its core end
`default_nettype none
package wdnmi_pkg;
	typedef enum logic [1:0] {
		WDNMI_CS_IDLE = 2'b00,
		WDNMI_CS_ACC = 2'b01,
		WDNMI_CS_CAP = 2'b10,
		WDNMI_CS_DONE = 2'b11
	} wdnmi_cstate_e;
endpackage : wdnmi_pkg
`default_nettype wire

// ==== logic/wdnmi_if.sv ====
// link between the watchdog device and the processor core
`default_nettype none
`include "wdnmi_consts.svh"
interface wdnmi_if;
	logic [`WDNMI_IO_AW-1:0] io_addr;
	logic io_wr;
	logic io_rd;
	logic [`WDNMI_IO_DW-1:0] io_wdata;
	logic [`WDNMI_IO_DW-1:0] io_rdata;
	logic nmi_req;
	modport dev (
		input io_addr,
		input io_wr,
		input io_rd,
		input io_wdata,
		output io_rdata,
		output nmi_req
	);
	modport core (
		output io_addr,
		output io_wr,
		output io_rd,
		output io_wdata,
		input io_rdata,
		input nmi_req
	);
endinterface : wdnmi_if
`default_nettype wire

// ==== logic/wdnmi_device.sv ====
// watchdog timer raising a non-maskable interrupt
`default_nettype none
`include "wdnmi_consts.svh"
module wdnmi_device
	import wdnmi_pkg::*;
#(
	parameter int OSC_DIV = `WDNMI_LSO_DIV,
	parameter int PRE_W = `WDNMI_PRE_W
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// link to the core
	wdnmi_if.dev link,
	// observation
	output logic [`WDNMI_CNT_W-1:0] count_out,
	output logic run_en_out,
	output logic tick_out,
	output logic lso_tick_out
);

	// ************************************************************
	// address decode
	// ************************************************************
	// the core drives one fixed address, yet the decode keeps stray accesses out
	function automatic logic ctrl_hit(input logic [`WDNMI_IO_AW-1:0] a);
		ctrl_hit = (a == `WDNMI_CTRL_ADDR);
	endfunction : ctrl_hit

	logic ctrl_wr;
	logic ctrl_rd;
	logic clear_req;

	assign ctrl_wr = link.io_wr && ctrl_hit(link.io_addr);
	assign ctrl_rd = link.io_rd && ctrl_hit(link.io_addr);
	// writing zero to the strobe does nothing
	assign clear_req = ctrl_wr && link.io_wdata[`WDNMI_CLR_BIT];

	// ************************************************************
	// low-speed oscillator stand-in
	// ************************************************************
	// one clock only: the oscillator is an enable pulse from sys_clk_in
	logic [15:0] osc_cnt_r;
	logic [15:0] osc_cnt_nxt;
	logic lso_tick;

	assign lso_tick = (osc_cnt_r == 16'(OSC_DIV - 1));

	always_comb begin
		if (lso_tick) begin
			osc_cnt_nxt = 16'h0000;
		end else begin
			osc_cnt_nxt = osc_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			osc_cnt_r <= 16'h0000;
		end else begin
			osc_cnt_r <= osc_cnt_nxt;
		end
	end

	// ************************************************************
	// divide to 256 Hz
	// ************************************************************
	// prescaler runs free and is not touched by the clear strobe,
	// which is why a timeout lands between just under and four seconds
	// the width is a parameter only so that a bench can shorten the timeout
	logic [PRE_W-1:0] pre_r;
	logic tick_256;

	assign tick_256 = lso_tick && (pre_r == {PRE_W{1'b1}});

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			pre_r <= '0;
		end else if (lso_tick) begin
			pre_r <= pre_r + PRE_W'(1);
		end
	end

	// ************************************************************
	// control register
	// ************************************************************
	// only the enable is stored; the strobe and bits 3 and 2 have no flip-flop
	logic run_en_r;

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			run_en_r <= `WDNMI_RUN_EN_RST;
		end else if (ctrl_wr) begin
			run_en_r <= link.io_wdata[`WDNMI_RUN_EN_BIT];
		end
	end

	// ************************************************************
	// watchdog counter
	// ************************************************************
	// counts whatever the core is doing, halt included
	logic [`WDNMI_CNT_W-1:0] cnt_r;
	logic [`WDNMI_CNT_W-1:0] cnt_nxt;
	logic advance;
	logic overflow;

	assign advance = run_en_r && tick_256;
	assign overflow = advance && (cnt_r == `WDNMI_CNT_LAST);

	always_comb begin
		if (clear_req) begin
			// clear beats a coincident tick; counting resumes next tick
			cnt_nxt = `WDNMI_CNT_RST;
		end else if (advance) begin
			cnt_nxt = cnt_r + `WDNMI_CNT_W'(1);
		end else begin
			cnt_nxt = cnt_r;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			cnt_r <= `WDNMI_CNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// ************************************************************
	// interrupt request
	// ************************************************************
	// a clear in the overflow cycle counts as serviced in time
	// a single pulse: the core holds it as pending, so nothing comes back
	logic nmi_r;

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			nmi_r <= 1'b0;
		end else begin
			nmi_r <= overflow && !clear_req;
		end
	end

	assign link.nmi_req = nmi_r;

	// ************************************************************
	// read back
	// ************************************************************
	// zero outside the cycle after a read, so a stray sample reads nothing
	logic [`WDNMI_IO_DW-1:0] rdata_r;
	logic [`WDNMI_IO_DW-1:0] rd_word;

	always_comb begin
		rd_word = '0;
		rd_word[`WDNMI_RUN_EN_BIT] = run_en_r;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			rdata_r <= '0;
		end else if (ctrl_rd) begin
			rdata_r <= rd_word;
		end else begin
			rdata_r <= '0;
		end
	end

	assign link.io_rdata = rdata_r;

	// ************************************************************
	// observation
	// ************************************************************
	logic tick_r;
	logic lso_r;

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			tick_r <= 1'b0;
			lso_r <= 1'b0;
		end else begin
			tick_r <= advance;
			lso_r <= lso_tick;
		end
	end

	assign count_out = cnt_r;
	assign run_en_out = run_en_r;
	assign tick_out = tick_r;
	assign lso_tick_out = lso_r;

endmodule : wdnmi_device
`default_nettype wire

// ==== logic/wdnmi_core.sv ====
// processor core end: io access, nmi acceptance, avalon control
`default_nettype none
`include "wdnmi_consts.svh"
module wdnmi_core
	import wdnmi_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// link to the watchdog
	wdnmi_if.core link,
	// avalon-mm slave
	input wire logic [`WDNMI_AV_AW-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// interrupt
	output logic irq_out
);

	// ************************************************************
	// bus sequencer
	// ************************************************************
	wdnmi_cstate_e st_r;
	logic [31:0] rdata_r;
	logic io_wr_r;
	logic io_rd_r;
	logic [`WDNMI_IO_DW-1:0] io_wdata_r;
	logic req;
	logic win;
	logic done_wr;
	logic halted_r;
	logic idis_r;
	logic mask_st_r;
	logic sp1_seen_r;
	logic nmi_pend_r;
	logic [15:0] pc_r;
	logic [`WDNMI_EV_W-1:0] ev_r;
	logic [`WDNMI_EV_W-1:0] msk_r;
	logic [31:0] loc_word;
	logic accept;

	assign req = avs_read_in || avs_write_in;
	assign win = (avs_address_in == `WDNMI_OFS_WINDOW);
	assign done_wr = (st_r == WDNMI_CS_DONE) && avs_write_in;
	assign avs_waitrequest_out = (st_r != WDNMI_CS_DONE);
	assign avs_readdata_out = rdata_r;

	always_comb begin
		loc_word = 32'h0000_0000;
		case (avs_address_in)
			`WDNMI_OFS_CORE_CTRL: begin
				loc_word[`WDNMI_IDIS_BIT] = idis_r;
			end
			`WDNMI_OFS_CORE_STAT: begin
				loc_word[`WDNMI_HALT_BIT] = halted_r;
				loc_word[`WDNMI_MASKST_BIT] = mask_st_r;
				loc_word[31:`WDNMI_PC_LSB] = pc_r;
			end
			`WDNMI_OFS_IRQ_STAT: begin
				loc_word[`WDNMI_EV_W-1:0] = ev_r;
			end
			`WDNMI_OFS_IRQ_MASK: begin
				loc_word[`WDNMI_EV_W-1:0] = msk_r;
			end
			default: begin
				loc_word = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			st_r <= WDNMI_CS_IDLE;
			rdata_r <= 32'h0000_0000;
			io_wr_r <= 1'b0;
			io_rd_r <= 1'b0;
			io_wdata_r <= '0;
		end else begin
			case (st_r)
				WDNMI_CS_IDLE: begin
					if (req && win) begin
						io_wr_r <= avs_write_in;
						io_rd_r <= avs_read_in;
						io_wdata_r <= avs_writedata_in[`WDNMI_IO_DW-1:0];
						st_r <= WDNMI_CS_ACC;
					end else if (req) begin
						rdata_r <= loc_word;
						st_r <= WDNMI_CS_DONE;
					end
				end
				WDNMI_CS_ACC: begin
					io_wr_r <= 1'b0;
					io_rd_r <= 1'b0;
					st_r <= WDNMI_CS_CAP;
				end
				WDNMI_CS_CAP: begin
					rdata_r <= {28'h0000000, link.io_rdata};
					st_r <= WDNMI_CS_DONE;
				end
				default: begin
					st_r <= WDNMI_CS_IDLE;
				end
			endcase
		end
	end

	assign link.io_addr = `WDNMI_CTRL_ADDR;
	assign link.io_wr = io_wr_r;
	assign link.io_rd = io_rd_r;
	assign link.io_wdata = io_wdata_r;

	// ************************************************************
	// core state
	// ************************************************************
	logic ctrl_wr;

	assign ctrl_wr = done_wr && (avs_address_in == `WDNMI_OFS_CORE_CTRL);
	// the disable flag is deliberately left out of this term
	assign accept = nmi_pend_r && !mask_st_r;

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			idis_r <= 1'b1;
			mask_st_r <= 1'b1;
			sp1_seen_r <= 1'b0;
		end else if (ctrl_wr) begin
			idis_r <= avs_writedata_in[`WDNMI_IDIS_BIT];
			if (avs_writedata_in[`WDNMI_SP1_BIT]) begin
				// re-setting the stack pointer masks again until the pair
				mask_st_r <= 1'b1;
				sp1_seen_r <= 1'b1;
			end else if (avs_writedata_in[`WDNMI_SP2_BIT] && sp1_seen_r) begin
				mask_st_r <= 1'b0;
				sp1_seen_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			nmi_pend_r <= 1'b0;
			halted_r <= 1'b0;
			pc_r <= `WDNMI_PC_RST;
		end else begin
			if (link.nmi_req) begin
				nmi_pend_r <= 1'b1;
			end else if (accept) begin
				nmi_pend_r <= 1'b0;
			end
			if (accept) begin
				halted_r <= 1'b0;
				pc_r <= `WDNMI_NMI_VECTOR;
			end else if (ctrl_wr && avs_writedata_in[`WDNMI_HALT_BIT]) begin
				halted_r <= 1'b1;
			end
		end
	end

	// ************************************************************
	// interrupt status and mask
	// ************************************************************
	logic [`WDNMI_EV_W-1:0] ev_set;
	logic [`WDNMI_EV_W-1:0] ev_clr;

	always_comb begin
		ev_set = '0;
		ev_set[`WDNMI_EV_TAKEN] = accept;
		ev_set[`WDNMI_EV_WAKE] = accept && halted_r;
		ev_clr = '0;
		if (done_wr && (avs_address_in == `WDNMI_OFS_IRQ_STAT)) begin
			ev_clr = avs_writedata_in[`WDNMI_EV_W-1:0];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			ev_r <= '0;
			msk_r <= '0;
		end else begin
			// a new event wins over a clear in the same cycle
			ev_r <= (ev_r & ~ev_clr) | ev_set;
			if (done_wr && (avs_address_in == `WDNMI_OFS_IRQ_MASK)) begin
				msk_r <= avs_writedata_in[`WDNMI_EV_W-1:0];
			end
		end
	end

	assign irq_out = |(ev_r & msk_r);

endmodule : wdnmi_core
`default_nettype wire

// ==== bench/wdnmi_monitor.sv ====
// assertions on the link between the watchdog and the core
`default_nettype none
`include "wdnmi_consts.svh"
module wdnmi_monitor #(
	parameter int OSC_DIV = 2,
	parameter int PRE_W = 7
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// link signals
	input wire logic [15:0] io_addr_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	input wire logic [3:0] io_wdata_in,
	input wire logic [3:0] io_rdata_in,
	input wire logic nmi_req_in
);
	localparam int TK = (1 << PRE_W) * OSC_DIV;
	localparam int LO = 1023 * TK;
	localparam int HI = 1024 * TK + 4;
	logic en_r;
	logic ok_r;
	int n_r;
	logic wr;
	assign wr = io_wr_in && (io_addr_in == `WDNMI_CTRL_ADDR);
	// timing is only exact since a clear with counting on: the prescaler may drift while off
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			en_r <= 1'b1;
			ok_r <= 1'b1;
			n_r <= 0;
		end else begin
			if (wr) en_r <= io_wdata_in[1];
			if (wr && !io_wdata_in[1]) ok_r <= 1'b0;
			else if (wr && io_wdata_in[0]) ok_r <= 1'b1;
			if ((wr && io_wdata_in[0]) || nmi_req_in) n_r <= 0;
			else if (en_r) n_r <= n_r + 1;
		end
	end
	// ****
	// checks
	// ****
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);
	idle_rdata_a: assert property (!$past(io_rd_in) |-> io_rdata_in == 4'h0)
		else $error("read data outside a read");
	read_shape_a: assert property ($past(io_rd_in) |-> io_rdata_in == {2'b00, en_r, 1'b0})
		else $error("read data not enable with zero bits");
	nmi_pulse_a: assert property (nmi_req_in |=> !nmi_req_in)
		else $error("interrupt request longer than one cycle");
	nmi_off_a: assert property (nmi_req_in |-> $past(en_r))
		else $error("interrupt while disabled");
	nmi_early_a: assert property (nmi_req_in && ok_r |-> n_r >= LO)
		else $error("interrupt before the timeout");
	nmi_late_a: assert property (ok_r && en_r |-> n_r <= HI)
		else $error("no interrupt after the timeout");
	reset_quiet_a: assert property ($rose(resetn_in) |-> !nmi_req_in && io_rdata_in == 4'h0)
		else $error("link busy after reset");
	clear_hold_a: assert property (wr && io_wdata_in[0] |-> ##2 !nmi_req_in [*8])
		else $error("interrupt just after a clear");
endmodule : wdnmi_monitor
`default_nettype wire

// ==== bench/tb_watchdog_nmi_timer.sv ====
// self-checking bench for the watchdog and its core end
`default_nettype none
`include "wdnmi_consts.svh"
module tb_watchdog_nmi_timer;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int D = 2;
	localparam int PW = 5;
	localparam int TK = (1 << PW) * D;
	localparam int TO = 1024 * TK;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] av_a = 5'h00;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wd = 32'h0;
	logic [31:0] av_q;
	logic av_wt;
	logic irq;
	logic [9:0] cnt;
	logic [9:0] c0;
	logic en;
	logic tk;
	logic lt;
	logic [31:0] seed = 32'h3F51825F;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int t0;
	int nl;
	wdnmi_if lnk ();
	wdnmi_device #(.OSC_DIV(D), .PRE_W(PW)) i_wdnmi_device (.sys_clk_in(clk),
		.resetn_in(rst_n), .link(lnk), .count_out(cnt), .run_en_out(en), .tick_out(tk),
		.lso_tick_out(lt));
	wdnmi_core i_wdnmi_core (.sys_clk_in(clk), .resetn_in(rst_n), .link(lnk),
		.avs_address_in(av_a), .avs_read_in(av_rd), .avs_write_in(av_wr),
		.avs_writedata_in(av_wd), .avs_readdata_out(av_q),
		.avs_waitrequest_out(av_wt), .irq_out(irq));
	wdnmi_monitor #(.OSC_DIV(D), .PRE_W(PW)) mon (.sys_clk_in(clk), .resetn_in(rst_n),
		.io_addr_in(lnk.io_addr), .io_wr_in(lnk.io_wr), .io_rd_in(lnk.io_rd),
		.io_wdata_in(lnk.io_wdata), .io_rdata_in(lnk.io_rdata),
		.nmi_req_in(lnk.nmi_req));
	initial begin
		forever #20 clk = ~clk;
	end
	// ****
	// helpers
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] win_exp(input logic [3:0] d);
		return {30'h0, d[1], 1'b0};
	endfunction : win_exp
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	// no cycle count assumed: a wait ends when av_wt drops, with only the run timeout as a limit
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		av_a <= a;
		av_wd <= d;
		av_wr <= w;
		av_rd <= !w;
		do @(posedge clk); while (av_wt !== 1'b0);
		q = av_q;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input string m);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e, m);
	endtask : rd
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == TO + 20000) begin
			bad_count++;
			$display("MISMATCH at %0t: run timed out", $time);
			complete_run();
		end
	end
	// ****
	// tests
	// ****
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		chk(32'(en), 32'h1, "enable after reset");
		rd(`WDNMI_OFS_WINDOW, 32'h2, "window after reset");
		rd(`WDNMI_OFS_CORE_STAT, 32'h2, "core state after reset");
		rd(`WDNMI_OFS_IRQ_STAT, 32'h0, "events after reset");
		wr(5'h1C, seed);
		rd(5'h1C, 32'h0, "unmapped");
		$display("done: reset values");
		while (cnt < 10'h2) @(posedge clk);
		c0 = cnt;
		t0 = cyc;
		nl = 0;
		while (cnt === c0) begin
			@(posedge clk);
			nl += int'(lt);
		end
		chk(32'(cyc - t0), 32'(TK), "tick period");
		chk(32'(nl), 32'(1 << PW), "oscillator ticks per count");
		chk(32'(tk), 32'h1, "tick pulse with count");
		chk(32'(cnt), 32'(c0 + 10'h1), "count step");
		$display("done: tick rate");
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			wr(`WDNMI_OFS_WINDOW, {seed[31:4], 4'(i)});
			rd(`WDNMI_OFS_WINDOW, win_exp(4'(i)), "window readback");
			chk(32'(en), 32'((i >> 1) & 1), "enable out");
		end
		$display("done: control codes");
		while (cnt < 10'h3) @(posedge clk);
		wr(`WDNMI_OFS_WINDOW, 32'h3);
		chk(32'(cnt > 10'h1), 32'h0, "count after clear");
		wr(`WDNMI_OFS_WINDOW, 32'h0);
		c0 = cnt;
		repeat (600) @(posedge clk);
		chk(32'(cnt), 32'(c0), "count frozen");
		wr(`WDNMI_OFS_WINDOW, 32'h3);
		t0 = cyc;
		$display("done: clear and stop");
		wr(`WDNMI_OFS_CORE_CTRL, 32'h3);
		rd(`WDNMI_OFS_CORE_STAT, 32'h3, "halted");
		wr(`WDNMI_OFS_IRQ_MASK, 32'h3);
		while (lnk.nmi_req !== 1'b1) @(posedge clk);
		chk(32'(cyc - t0 > TO - TK - 8 && cyc - t0 < TO + 8), 32'h1, "timeout");
		rd(`WDNMI_OFS_CORE_STAT, 32'h3, "held while masked");
		wr(`WDNMI_OFS_CORE_CTRL, 32'h6);
		wr(`WDNMI_OFS_CORE_CTRL, 32'hA);
		rd(`WDNMI_OFS_CORE_STAT, 32'h01000000, "vector and wake");
		rd(`WDNMI_OFS_IRQ_STAT, 32'h3, "taken and woke");
		chk(32'(irq), 32'h1, "irq raised");
		wr(`WDNMI_OFS_IRQ_MASK, 32'h0);
		@(posedge clk);
		chk(32'(irq), 32'h0, "irq masked");
		wr(`WDNMI_OFS_IRQ_MASK, 32'h3);
		wr(`WDNMI_OFS_IRQ_STAT, 32'h3);
		@(posedge clk);
		chk(32'(irq), 32'h0, "irq cleared");
		$display("done: timeout in halt");
		complete_run();
	end
endmodule : tb_watchdog_nmi_timer
`default_nettype wire
